// ### hw/vamm_pkg.sv
// Constants and types for the vector and memory map block.
// Assumes a 4-bit core with 13-bit program and 12-bit data addresses.
package vamm_pkg;

  // Address fields, stack width and source count
  localparam int STEP_W = 8;
  localparam int PAGE_W = 4;
  localparam int PA_W = 13;
  localparam int DA_W = 12;
  localparam int SP_W = 8;
  localparam int NUM_SRC = 6;
  localparam int STEPS_PER_PAGE = 256;

  // Start address after reset: bank 0, page 1, step 00H
  localparam logic RESET_BANK = 1'b0;
  localparam logic [PAGE_W-1:0] RESET_PAGE = 4'h1;
  localparam logic [STEP_W-1:0] RESET_STEP = 8'h00;

  // Vector page and step window
  localparam logic [PAGE_W-1:0] VEC_PAGE = 4'h1;
  localparam logic [STEP_W-1:0] VEC_STEP_LO = 8'h02;
  localparam logic [STEP_W-1:0] VEC_STEP_HI = 8'h0C;

  // Sources, lowest priority first
  localparam int SRC_CLOCK = 0;
  localparam int SRC_STOPWATCH = 1;
  localparam int SRC_KEY_A = 2;
  localparam int SRC_KEY_B = 3;
  localparam int SRC_SERIAL = 4;
  localparam int SRC_PTIMER = 5;
  localparam logic [STEP_W-1:0] VEC_STEP [NUM_SRC] =
    '{8'h02, 8'h04, 8'h06, 8'h08, 8'h0A, 8'h0C};

  // Stack cost of a call or interrupt entry, in words
  localparam logic [SP_W-1:0] STACK_WORDS = 8'h03;
  localparam logic [SP_W-1:0] SP_RESET = 8'h00;

  // Data memory regions
  localparam logic [DA_W-1:0] MREG_LO = 12'h000;
  localparam logic [DA_W-1:0] MREG_HI = 12'h00F;
  localparam logic [DA_W-1:0] RAM_LO = 12'h000;
  localparam logic [DA_W-1:0] DISP_A_LO = 12'hE00;
  localparam logic [DA_W-1:0] DISP_B_LO = 12'hE80;
  localparam logic [DA_W-1:0] DISP40_A_HI = 12'hE4F;
  localparam logic [DA_W-1:0] DISP40_B_HI = 12'hECF;
  localparam logic [DA_W-1:0] DISP51_A_HI = 12'hE65;
  localparam logic [DA_W-1:0] DISP51_B_HI = 12'hEF5;
  localparam logic [DA_W-1:0] IO_A_LO = 12'hF00;
  localparam logic [DA_W-1:0] IO_A_HI = 12'hF4F;
  localparam logic [DA_W-1:0] IO_B_LO = 12'hFC0;
  localparam logic [DA_W-1:0] IO_B_HI = 12'hFFF;

  // Device variants
  typedef enum logic [1:0] {
    VAMM_ROM4K = 2'h0,
    VAMM_ROM6K = 2'h1,
    VAMM_ROM5K = 2'h2,
    VAMM_ROM8K = 2'h3
  } vamm_variant_t;

  localparam logic [4:0] BANK1_PAGES [4] = '{5'h00, 5'h08, 5'h04, 5'h10};
  localparam logic [DA_W-1:0] RAM_HI [4] = '{12'h17F, 12'h27F, 12'h47F, 12'h2FF};

  // Data region codes, one-hot
  typedef enum logic [3:0] {
    VAMM_UNUSED = 4'b0001,
    VAMM_RAM = 4'b0010,
    VAMM_DISP = 4'b0100,
    VAMM_IO = 4'b1000
  } vamm_region_t;

endpackage

// ### hw/vamm_irq_arbiter.sv
// Factor flags and fixed-priority vector choice for six sources.
// Sources and CPU strobes are on mclk; no synchronisers needed.
`timescale 1ns/10ps
`default_nettype none
module vamm_irq_arbiter (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  input wire logic ce,
  // Sources and CPU side
  input wire logic [vamm_pkg::NUM_SRC-1:0] src_event,
  input wire logic [vamm_pkg::NUM_SRC-1:0] src_enable,
  input wire logic [vamm_pkg::NUM_SRC-1:0] factor_read,
  input wire logic cpu_int_enable,
  input wire logic int_ack,
  // Results
  output logic [vamm_pkg::NUM_SRC-1:0] factor_flag,
  output logic int_request,
  output logic [vamm_pkg::STEP_W-1:0] vec_step,
  output logic vec_valid
);

  typedef struct packed {
    logic [vamm_pkg::NUM_SRC-1:0] flag;
    logic req;
    logic [vamm_pkg::STEP_W-1:0] step;
    logic valid;
  } vamm_arb_t;

  vamm_arb_t cur;
  vamm_arb_t nxt;
  logic [vamm_pkg::NUM_SRC-1:0] live;

  // Highest set index wins
  function automatic logic [vamm_pkg::STEP_W-1:0] pick(
    input logic [vamm_pkg::NUM_SRC-1:0] v);
    logic [vamm_pkg::STEP_W-1:0] s;
    s = vamm_pkg::VEC_STEP[vamm_pkg::SRC_CLOCK];
    for (int i = 0; i < vamm_pkg::NUM_SRC; i++)
    begin
      if (v[i])
        s = vamm_pkg::VEC_STEP[i];
    end
    return s;
  endfunction

  // Flags, request and vector
  always_comb
  begin
    nxt = cur;
    live = cur.flag & src_enable;
    // Set beats a read in the same cycle so no event is lost
    nxt.flag = src_event | (cur.flag & ~factor_read);
    // Ack leaves every flag set, so losers keep asking after service
    nxt.req = (|live) & cpu_int_enable & ~int_ack;
    nxt.valid = 1'b0;
    if (int_ack && (|live))
    begin
      nxt.step = pick(live);
      nxt.valid = 1'b1;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
      cur <= '0;
    else if (ce)
      cur <= nxt;
  end

  assign factor_flag = cur.flag;
  assign int_request = cur.req;
  assign vec_step = cur.step;
  assign vec_valid = cur.valid;

endmodule
`default_nettype wire

// ### hw/vamm_data_decode.sv
// Data address decoder: RAM, memory registers, display and I/O areas.
// Address and pointer come from core logic on mclk.
`timescale 1ns/10ps
`default_nettype none
module vamm_data_decode #(
  parameter vamm_pkg::vamm_variant_t VARIANT = vamm_pkg::VAMM_ROM8K
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  input wire logic ce,
  // Access request
  input wire logic [vamm_pkg::DA_W-1:0] data_addr,
  input wire logic use_pointer,
  input wire logic [3:0] memory_register_pointer,
  // Decoded result
  output logic [vamm_pkg::DA_W-1:0] eff_addr,
  output logic [3:0] region,
  output logic mreg_hit
);

  typedef struct packed {
    logic [vamm_pkg::DA_W-1:0] addr;
    logic [3:0] region;
    logic mreg;
  } vamm_dec_t;

  vamm_dec_t cur;
  vamm_dec_t nxt;
  logic [vamm_pkg::DA_W-1:0] a;
  logic disp;
  logic io;

  function automatic logic in_range(input logic [vamm_pkg::DA_W-1:0] x,
    input logic [vamm_pkg::DA_W-1:0] lo, input logic [vamm_pkg::DA_W-1:0] hi);
    return (x >= lo) && (x <= hi);
  endfunction

  localparam bit SEG40 = (VARIANT == vamm_pkg::VAMM_ROM4K) ||
    (VARIANT == vamm_pkg::VAMM_ROM6K);

  // Region lookup; anything not listed has no storage
  always_comb
  begin
    nxt = cur;
    // Pointer selects one of the first sixteen RAM words
    a = use_pointer ? {8'h00, memory_register_pointer} : data_addr;
    if (SEG40)
      disp = in_range(a, vamm_pkg::DISP_A_LO, vamm_pkg::DISP40_A_HI) ||
        in_range(a, vamm_pkg::DISP_B_LO, vamm_pkg::DISP40_B_HI);
    else
      disp = in_range(a, vamm_pkg::DISP_A_LO, vamm_pkg::DISP51_A_HI) ||
        in_range(a, vamm_pkg::DISP_B_LO, vamm_pkg::DISP51_B_HI);
    io = in_range(a, vamm_pkg::IO_A_LO, vamm_pkg::IO_A_HI) ||
      in_range(a, vamm_pkg::IO_B_LO, vamm_pkg::IO_B_HI);
    nxt.addr = a;
    nxt.mreg = in_range(a, vamm_pkg::MREG_LO, vamm_pkg::MREG_HI);
    if (in_range(a, vamm_pkg::RAM_LO, vamm_pkg::RAM_HI[VARIANT]))
      nxt.region = vamm_pkg::VAMM_RAM;
    else if (disp)
      nxt.region = vamm_pkg::VAMM_DISP;
    else if (io)
      nxt.region = vamm_pkg::VAMM_IO;
    else
      nxt.region = vamm_pkg::VAMM_UNUSED;
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      cur.addr <= '0;
      cur.region <= vamm_pkg::VAMM_UNUSED;
      cur.mreg <= 1'b0;
    end
    else if (ce)
      cur <= nxt;
  end

  assign eff_addr = cur.addr;
  assign region = cur.region;
  assign mreg_hit = cur.mreg;

endmodule
`default_nettype wire

// ### hw/vamm_top.sv
// Reset and interrupt vectoring, program address map and stack pointer.
// Sits beside the CPU core on mclk; all strobes are one-cycle pulses
// from logic on the same clock, so nothing here is synchronised.
//
// Overview of operation
// - Reset starts fetch at bank 0, page 1, step 0
// - All vectors sit in page 1, steps 02H-0CH
// - Six fixed vectors, clock lowest, timer highest
// - Simultaneous requests take the highest priority vector
// - Pages of 256 steps form program address
// - Smallest variant: bank 0 only, 0000H-0FFFH
// - Largest variant: both banks, 0000H-1FFFH
// - Call or interrupt entry pushes three words
// - RAM 000H-00FH reachable through the pointer
// - 40-segment display memory E00H-E4FH, E80H-ECFH
// - 51-segment display memory E00H-E65H, E80H-EF5H
// - Unused addresses have no storage behind them
// - Factor flag clears when the CPU reads it
`timescale 1ns/10ps
`default_nettype none
module vamm_top #(
  parameter vamm_pkg::vamm_variant_t VARIANT = vamm_pkg::VAMM_ROM8K
) (
  // Clock, reset, enable
  input wire logic mclk,
  input wire logic rst,
  input wire logic ce,
  // Program counter check
  input wire logic pc_bank,
  input wire logic [vamm_pkg::PAGE_W-1:0] pc_page,
  input wire logic [vamm_pkg::STEP_W-1:0] pc_step,
  output logic [vamm_pkg::PA_W-1:0] prog_addr,
  output logic prog_addr_valid,
  // Fetch redirect to the core
  output logic [vamm_pkg::PA_W-1:0] fetch_addr,
  output logic fetch_load,
  // Interrupt sources and CPU handshake
  input wire logic [vamm_pkg::NUM_SRC-1:0] src_event,
  input wire logic [vamm_pkg::NUM_SRC-1:0] src_enable,
  input wire logic [vamm_pkg::NUM_SRC-1:0] factor_read,
  input wire logic cpu_int_enable,
  input wire logic int_ack,
  output logic [vamm_pkg::NUM_SRC-1:0] factor_flag,
  output logic int_request,
  // Stack
  input wire logic call_push,
  input wire logic ret_pop,
  output logic [vamm_pkg::SP_W-1:0] stack_ptr,
  // Data access
  input wire logic [vamm_pkg::DA_W-1:0] data_addr,
  input wire logic use_pointer,
  input wire logic [3:0] memory_register_pointer,
  output logic [vamm_pkg::DA_W-1:0] data_eff_addr,
  output logic [3:0] data_region,
  output logic data_mreg_hit
);

  typedef enum logic [1:0] {
    VAMM_BOOT = 2'b01,
    VAMM_RUN = 2'b10
  } vamm_state_t;

  typedef struct packed {
    vamm_state_t state;
    logic [vamm_pkg::PA_W-1:0] fetch;
    logic load;
    logic [vamm_pkg::PA_W-1:0] prog;
    logic prog_ok;
    logic [vamm_pkg::SP_W-1:0] sp;
  } vamm_top_state_t;

  vamm_top_state_t cur;
  vamm_top_state_t nxt;
  logic [vamm_pkg::STEP_W-1:0] vec_step;
  logic vec_valid;

  // Joins bank, page and step into one program address
  function automatic logic [vamm_pkg::PA_W-1:0] join_addr(input logic bank,
    input logic [vamm_pkg::PAGE_W-1:0] page, input logic [vamm_pkg::STEP_W-1:0] step);
    return {bank, page, step};
  endfunction

  // Whether a page holds ROM in this variant
  function automatic logic rom_present(input logic bank,
    input logic [vamm_pkg::PAGE_W-1:0] page);
    logic [4:0] p;
    p = {1'b0, page};
    if (!bank)
      return 1'b1;
    return p < vamm_pkg::BANK1_PAGES[VARIANT];
  endfunction

  // Interrupt flags and arbitration
  vamm_irq_arbiter u_arb (
    .mclk(mclk),
    .rst(rst),
    .ce(ce),
    .src_event(src_event),
    .src_enable(src_enable),
    .factor_read(factor_read),
    .cpu_int_enable(cpu_int_enable),
    .int_ack(int_ack),
    .factor_flag(factor_flag),
    .int_request(int_request),
    .vec_step(vec_step),
    .vec_valid(vec_valid)
  );

  // Data address decoding
  vamm_data_decode #(
    .VARIANT(VARIANT)
  ) u_dec (
    .mclk(mclk),
    .rst(rst),
    .ce(ce),
    .data_addr(data_addr),
    .use_pointer(use_pointer),
    .memory_register_pointer(memory_register_pointer),
    .eff_addr(data_eff_addr),
    .region(data_region),
    .mreg_hit(data_mreg_hit)
  );

  // Boot redirect, vector redirect, address check, stack pointer
  always_comb
  begin
    nxt = cur;
    nxt.load = 1'b0;
    case (cur.state)
      VAMM_BOOT:
      begin
        // One redirect to the start address, then normal running
        nxt.fetch = join_addr(vamm_pkg::RESET_BANK, vamm_pkg::RESET_PAGE,
          vamm_pkg::RESET_STEP);
        nxt.load = 1'b1;
        nxt.state = VAMM_RUN;
      end
      VAMM_RUN:
      begin
        if (vec_valid)
        begin
          // Vector steps are confined to page 1 of bank 0
          nxt.fetch = join_addr(1'b0, vamm_pkg::VEC_PAGE, vec_step);
          nxt.load = 1'b1;
        end
      end
      default:
        nxt.state = VAMM_BOOT;
    endcase
    nxt.prog = join_addr(pc_bank, pc_page, pc_step);
    nxt.prog_ok = rom_present(pc_bank, pc_page);
    // Push wins if both come together; the core never asks for both
    if (call_push || int_ack)
      nxt.sp = cur.sp - vamm_pkg::STACK_WORDS;
    else if (ret_pop)
      nxt.sp = cur.sp + vamm_pkg::STACK_WORDS;
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      cur.state <= VAMM_BOOT;
      cur.fetch <= '0;
      cur.load <= 1'b0;
      cur.prog <= '0;
      cur.prog_ok <= 1'b0;
      cur.sp <= vamm_pkg::SP_RESET;
    end
    else if (ce)
      cur <= nxt;
  end

  // All outputs straight from flops
  assign fetch_addr = cur.fetch;
  assign fetch_load = cur.load;
  assign prog_addr = cur.prog;
  assign prog_addr_valid = cur.prog_ok;
  assign stack_ptr = cur.sp;

endmodule
`default_nettype wire

// ### verification/vamm_chk.sv
// Concurrent checks on the vector and memory map top.
// Bound onto vamm_top from the bench; sees only its ports.
`timescale 1ns/10ps
`default_nettype none
module vamm_chk #(
  parameter vamm_pkg::vamm_variant_t VARIANT = vamm_pkg::VAMM_ROM8K
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  input wire logic ce,
  // Program side
  input wire logic pc_bank,
  input wire logic [3:0] pc_page,
  input wire logic [7:0] pc_step,
  input wire logic [12:0] prog_addr,
  input wire logic prog_addr_valid,
  input wire logic [12:0] fetch_addr,
  input wire logic fetch_load,
  // Interrupt side
  input wire logic [5:0] src_event,
  input wire logic [5:0] src_enable,
  input wire logic [5:0] factor_read,
  input wire logic cpu_int_enable,
  input wire logic int_ack,
  input wire logic [5:0] factor_flag,
  input wire logic int_request,
  // Stack
  input wire logic call_push,
  input wire logic ret_pop,
  input wire logic [7:0] stack_ptr
);
  logic [5:0] live;

  // Enabled pending sources; highest index wins
  assign live = factor_flag & src_enable;

  function automatic logic [7:0] top_step(input logic [5:0] v);
    top_step = 8'h00;
    for (int i = 0; i < 6; i++)
      if (v[i])
        top_step = 8'(2 * i + 2);
  endfunction

  default clocking @(posedge mclk);
  endclocking
  default disable iff (rst);

  a_boot_start: assert property ($fell(rst) |-> ##[0:2] fetch_load && fetch_addr == 13'h0100)
    else $error("boot redirect wrong");
  a_pc_follow: assert property (ce && !$past(rst) |=> prog_addr == $past({pc_bank, pc_page, pc_step}))
    else $error("program address wrong");
  a_rom_valid: assert property (ce && !$past(rst) |=> prog_addr_valid ==
    $past(!pc_bank || {1'b0, pc_page} < vamm_pkg::BANK1_PAGES[VARIANT]))
    else $error("rom valid wrong");
  a_vector_pick: assert property (ce && int_ack && |live |-> ##2 fetch_load &&
    fetch_addr == {5'h01, $past(top_step(live), 2)})
    else $error("vector choice wrong");
  a_vector_page: assert property (fetch_load |-> fetch_addr[12:8] == 5'h01 &&
    !fetch_addr[0] && fetch_addr[7:0] <= 8'h0C)
    else $error("vector outside page window");
  a_flag_track: assert property (ce && !$past(rst) |=>
    factor_flag == $past(src_event | (factor_flag & ~factor_read)))
    else $error("factor flag wrong");
  a_req_pending: assert property (ce && !$past(rst) |=>
    int_request == $past(|live && cpu_int_enable && !int_ack))
    else $error("request level wrong");
  a_stack_step: assert property (ce && !$past(rst) |=> stack_ptr ==
    $past(call_push || int_ack ? stack_ptr - 8'h03 : ret_pop ? stack_ptr + 8'h03 : stack_ptr))
    else $error("stack step wrong");

  c_ack: cover property (int_ack && |live);
  c_top_vec: cover property (fetch_load && fetch_addr == 13'h010C);
  c_push: cover property (call_push && ce);
endmodule
`default_nettype wire

// ### verification/vamm_cpu_model.sv
// CPU core stand-in: acknowledges interrupt requests.
// Commands change on the falling edge; ack moves on the rising edge.
`timescale 1ns/10ps
`default_nettype none
module vamm_cpu_model (
  // Clock and commands
  input wire logic mclk,
  input wire logic arm,
  input wire logic ack_now,
  input wire logic [3:0] ack_delay,
  // Core side
  input wire logic int_request,
  output logic int_ack
);
  int wait_cnt = 0;
  logic fired = 1'b0;

  // One ack per arming, so a still-high request is not taken twice
  always @(posedge mclk)
  begin
    int_ack <= ack_now;
    if (!arm)
    begin
      fired <= 1'b0;
      wait_cnt <= 0;
    end
    else if (int_request && !fired)
    begin
      if (wait_cnt >= int'(ack_delay))
      begin
        int_ack <= 1'b1;
        fired <= 1'b1;
      end
      else
        wait_cnt <= wait_cnt + 1;
    end
  end
endmodule
`default_nettype wire

// ### verification/vamm_top_bench.sv
// Self-checking bench for vamm_top, smallest and largest variants.
// CPU model acks requests; bench drives on the falling edge.
`timescale 1ns/10ps
`default_nettype none
bind vamm_top vamm_chk #(.VARIANT(VARIANT)) u_chk (.*);
module vamm_top_bench;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic pc_bank = 1'b0;
  logic [3:0] pc_page = 4'h0;
  logic [7:0] pc_step = 8'h00;
  logic [5:0] src_event = 6'h00;
  logic [5:0] src_enable = 6'h3F;
  logic [5:0] factor_read = 6'h00;
  logic cpu_int_enable = 1'b1;
  logic call_push = 1'b0;
  logic ret_pop = 1'b0;
  logic [11:0] data_addr = 12'h000;
  logic use_pointer = 1'b0;
  logic [3:0] memory_register_pointer = 4'h0;
  logic arm = 1'b0;
  logic ack_now = 1'b0;
  logic [3:0] ack_delay = 4'h0;
  logic int_ack, prog_addr_valid, fetch_load, int_request, data_mreg_hit;
  logic [12:0] prog_addr, fetch_addr;
  logic [12:0] prog_addr_b;
  logic prog_addr_valid_b;
  logic [3:0] data_region_b;
  logic [5:0] factor_flag;
  logic [7:0] stack_ptr;
  logic [11:0] data_eff_addr;
  logic [3:0] data_region;
  int error_cnt = 0;
  int n_checks = 0;
  int cycles = 0;

  vamm_top #(.VARIANT(vamm_pkg::VAMM_ROM4K)) u_dut (.*);
  // Largest variant on the same stimulus: second bank and 51-segment display
  vamm_top #(.VARIANT(vamm_pkg::VAMM_ROM8K)) u_dut_8k (.mclk(mclk), .rst(rst), .ce(ce),
    .pc_bank(pc_bank), .pc_page(pc_page), .pc_step(pc_step),
    .prog_addr(prog_addr_b), .prog_addr_valid(prog_addr_valid_b),
    .fetch_addr(), .fetch_load(),
    .src_event(src_event), .src_enable(src_enable), .factor_read(factor_read),
    .cpu_int_enable(cpu_int_enable), .int_ack(int_ack),
    .factor_flag(), .int_request(),
    .call_push(call_push), .ret_pop(ret_pop), .stack_ptr(),
    .data_addr(data_addr), .use_pointer(use_pointer),
    .memory_register_pointer(memory_register_pointer),
    .data_eff_addr(), .data_region(data_region_b), .data_mreg_hit());
  vamm_cpu_model u_cpu (.mclk(mclk), .arm(arm), .ack_now(ack_now),
    .ack_delay(ack_delay), .int_request(int_request), .int_ack(int_ack));

  // 250 MHz clock
  always #2 mclk = ~mclk;

  // Hang guard, well above the hundred or so cycles the tests need
  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      error_cnt++;
      results();
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(negedge mclk);
  endtask

  task automatic fire(input logic [5:0] ev);
    src_event = ev;
    step(1);
    src_event = 6'h00;
  endtask

  task automatic clear(input logic [5:0] v);
    factor_read = v;
    step(1);
    factor_read = 6'h00;
  endtask

  // Bounded wait for a redirect pulse
  task automatic wait_load();
    int k;
    k = 0;
    while (fetch_load !== 1'b1 && k < 30)
    begin
      step(1);
      k++;
    end
    chk(16'(fetch_load), 16'h0001);
  endtask

  task automatic t_boot();
    wait_load();
    chk(16'(fetch_addr), 16'h0100);
    $display("boot done");
  endtask

  // Masked flag plus ack: no redirect, stack still pushes
  task automatic t_refused();
    src_enable = 6'h00;
    fire(6'h01);
    ack_now = 1'b1;
    step(1);
    ack_now = 1'b0;
    repeat (4)
    begin
      step(1);
      chk(16'(fetch_load), 16'h0000);
    end
    chk(16'(factor_flag), 16'h0001);
    chk(16'(stack_ptr), 16'h00FD);
    call_push = 1'b1;
    step(1);
    call_push = 1'b0;
    chk(16'(stack_ptr), 16'h00FA);
    ret_pop = 1'b1;
    step(1);
    ret_pop = 1'b0;
    chk(16'(stack_ptr), 16'h00FD);
    clear(6'h01);
    src_enable = 6'h3F;
    $display("refused done");
  endtask

  task automatic t_freeze();
    ce = 1'b0;
    call_push = 1'b1;
    step(1);
    call_push = 1'b0;
    step(1);
    chk(16'(stack_ptr), 16'h00FD);
    ce = 1'b1;
    $display("freeze done");
  endtask

  task automatic t_prog();
    pc_page = 4'hF;
    pc_step = 8'hFF;
    step(1);
    chk(16'(prog_addr), 16'h0FFF);
    chk(16'(prog_addr_valid), 16'h0001);
    pc_bank = 1'b1;
    pc_page = 4'h0;
    pc_step = 8'h00;
    step(1);
    chk(16'(prog_addr), 16'h1000);
    chk(16'(prog_addr_valid), 16'h0000);
    chk(16'(prog_addr_valid_b), 16'h0001);
    pc_page = 4'hF;
    pc_step = 8'hFF;
    step(1);
    chk(16'(prog_addr_b), 16'h1FFF);
    chk(16'(prog_addr_valid_b), 16'h0001);
    chk(16'(prog_addr_valid), 16'h0000);
    $display("program map done");
  endtask

  task automatic t_data();
    logic [11:0] a_tab [8] = '{12'h000, 12'h17F, 12'h180, 12'hE4F,
      12'hE50, 12'hE80, 12'hECF, 12'hED0};
    logic [3:0] r_tab [8] = '{4'h2, 4'h2, 4'h1, 4'h4, 4'h1, 4'h4, 4'h4, 4'h1};
    logic [11:0] b_tab [8] = '{12'h2FF, 12'h300, 12'hE65, 12'hE66,
      12'hEF5, 12'hEF6, 12'hF00, 12'hF50};
    logic [3:0] b_reg [8] = '{4'h2, 4'h1, 4'h4, 4'h1, 4'h4, 4'h1, 4'h8, 4'h1};
    for (int i = 0; i < 8; i++)
    begin
      data_addr = a_tab[i];
      step(1);
      chk(16'(data_region), 16'(r_tab[i]));
      chk(16'(data_mreg_hit), 16'(i == 0));
    end
    // Largest variant: RAM top, 51-segment display ends, I/O start
    for (int i = 0; i < 8; i++)
    begin
      data_addr = b_tab[i];
      step(1);
      chk(16'(data_region_b), 16'(b_reg[i]));
    end
    use_pointer = 1'b1;
    memory_register_pointer = 4'hA;
    step(1);
    chk(16'(data_eff_addr), 16'h000A);
    chk(16'(data_mreg_hit), 16'h0001);
    use_pointer = 1'b0;
    $display("data map done");
  endtask

  // Each source raised together with all lower ones, slower acks later
  task automatic t_prio();
    for (int i = 0; i < 6; i++)
    begin
      fire(6'((1 << (i + 1)) - 1));
      ack_delay = 4'(i);
      arm = 1'b1;
      wait_load();
      chk(16'(fetch_addr), 16'(16'h0102 + 2 * i));
      arm = 1'b0;
      clear(6'h3F);
      chk(16'(factor_flag), 16'h0000);
    end
    $display("priority done");
  endtask

  task automatic t_pending();
    fire(6'h12);
    arm = 1'b1;
    wait_load();
    chk(16'(fetch_addr), 16'h010A);
    chk(16'(factor_flag), 16'h0012);
    chk(16'(int_request), 16'h0001);
    arm = 1'b0;
    clear(6'h10);
    arm = 1'b1;
    wait_load();
    chk(16'(fetch_addr), 16'h0104);
    arm = 1'b0;
    clear(6'h02);
    $display("pending done");
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Reset for six cycles, then the scenarios in turn
  initial
  begin
    step(6);
    rst = 1'b0;
    t_boot();
    t_refused();
    t_freeze();
    t_prog();
    t_data();
    t_prio();
    t_pending();
    results();
  end
endmodule
`default_nettype wire
